// ==== nfcd_host.sv ====
// Host-side command sequencer for an x16 asynchronous NOR flash.
// Assumes the host port runs on clk_i and the flash pins are async.
`timescale 1ns/1ns
module nfcd_host
   import nfcd_pkg::*;
#(
   parameter int MAX_WORDS = 256
)(
   input  wire logic              clk_i,
   input  wire logic              reset_i,
   input  wire logic              cmd_valid_i,
   input  wire nfcd_cmd_t         cmd_i,
   output logic                   cmd_ready_o,
   input  wire logic              word_valid_i,
   input  wire nfcd_word_t        word_i,
   output logic                   word_ready_o,
   output logic                   done_o,
   output logic                   err_o,
   output logic                   rvalid_o,
   output logic [DATA_W-1:0]      rdata_o,
   output logic                   bypass_o,
   output logic                   overlay_space_o,
   output nfcd_pins_t             pins_o,
   input  wire logic [DATA_W-1:0] dq_i
);

   typedef enum logic [3:0] {
      S_IDLE = 4'h1, S_STEP = 4'h2, S_LOAD = 4'h4, S_WAIT = 4'h8
   } nfcd_hst_t;

   typedef struct packed {
      nfcd_hst_t         st;
      nfcd_cmd_t         cmd;
      logic [3:0]        idx;
      logic [CNT_W-1:0]  rem;
      logic              byp;
      logic              ovl;
      logic              ready;
      logic              wready;
      logic              done;
      logic              err;
      logic              rvalid;
      logic [DATA_W-1:0] rdata;
      logic              start;
      nfcd_req_t         req;
   } nfcd_host_state_t;

   localparam logic [CNT_W-1:0] MAXW = CNT_W'(MAX_WORDS);

   nfcd_host_state_t  s_reg;
   nfcd_host_state_t  s_next;
   nfcd_step_t        step;
   logic              cyc_done;
   logic [DATA_W-1:0] cyc_rdata;

   // Builds one bus step from its kind, address and data.
   function automatic nfcd_step_t mk(input nfcd_kind_t k,
                                     input logic [ADDR_W-1:0] a,
                                     input logic [7:0] d);
      nfcd_step_t s;
      s.kind = k;
      s.addr = a;
      s.data = DATA_W'(d);
      return s;
   endfunction

   // Returns the bus step at position i of an operation.
   function automatic nfcd_step_t fn_step(input nfcd_op_t op,
                                          input logic [3:0] i,
                                          input logic byp);
      nfcd_step_t s;
      logic       pre;
      logic [3:0] j;
      s   = mk(K_END, A_ZERO, 8'h00);
      // Unlock prefix; bypass mode omits it for program and erase.
      pre = (op == OP_BYP_ENTER) || (op == OP_ID_ENTER) ||
            (!byp && (op == OP_WORD_PROG || op == OP_BUF_PROG ||
                      op == OP_CHIP_ERASE || op == OP_SECT_ERASE));
      j   = pre ? 4'(i - 4'h2) : i;
      if (pre && i == 4'h0) begin
         s = mk(K_WR, A_555, 8'hAA);
      end else if (pre && i == 4'h1) begin
         s = mk(K_WR, A_2AA, 8'h55);
      end else begin
         case (op)
            OP_READ: begin
               if (j == 4'h0) s = mk(K_RD, A_ZERO, 8'h00);
            end
            OP_RESET: begin
               if (j == 4'h0) s = mk(K_WR, A_ZERO, 8'hF0);
            end
            OP_SR_READ: begin
               if (j == 4'h0) s = mk(K_WR, A_555, 8'h70);
               if (j == 4'h1) s = mk(K_RD, A_ZERO, 8'h00);
            end
            OP_SR_CLEAR: begin
               if (j == 4'h0) s = mk(K_WR, A_555, 8'h71);
            end
            OP_WORD_PROG: begin
               if (j == 4'h0) s = mk(K_WR, A_555, 8'hA0);
               if (j == 4'h1) s = mk(K_WRU, A_ZERO, 8'h00);
            end
            OP_BUF_PROG: begin
               if (j == 4'h0) s = mk(K_WRS, A_ZERO, 8'h25);
               if (j == 4'h1) s = mk(K_CNT, A_ZERO, 8'h00);
               if (j == 4'h2) s = mk(K_LOAD, A_ZERO, 8'h00);
               if (j == 4'h3) s = mk(K_WRS, A_ZERO, 8'h29);
            end
            OP_BYP_ENTER: begin
               if (j == 4'h0) s = mk(K_WR, A_555, 8'h20);
            end
            OP_BYP_EXIT: begin
               if (j == 4'h0) s = mk(K_WR, A_ZERO, 8'h90);
               if (j == 4'h1) s = mk(K_WR, A_ZERO, 8'h00);
            end
            OP_CHIP_ERASE, OP_SECT_ERASE: begin
               if (j == 4'h0) s = mk(K_WR, A_555, 8'h80);
               if (!byp && j == 4'h1) s = mk(K_WR, A_555, 8'hAA);
               if (!byp && j == 4'h2) s = mk(K_WR, A_2AA, 8'h55);
               if (j == (byp ? 4'h1 : 4'h3)) begin
                  if (op == OP_CHIP_ERASE) begin
                     s = mk(K_WR, A_555, 8'h10);
                  end else begin
                     s = mk(K_WRS, A_ZERO, 8'h30);
                  end
               end
            end
            OP_SUSP_LEG: begin
               if (j == 4'h0) s = mk(K_WR, A_ZERO, 8'hB0);
            end
            OP_RES_LEG: begin
               if (j == 4'h0) s = mk(K_WR, A_ZERO, 8'h30);
            end
            OP_SUSP_ENH: begin
               if (j == 4'h0) s = mk(K_WR, A_ZERO, 8'h51);
            end
            OP_RES_ENH: begin
               if (j == 4'h0) s = mk(K_WR, A_ZERO, 8'h50);
            end
            OP_EVAL_ERASE: begin
               if (j == 4'h0) s = mk(K_WRS, A_555, 8'h35);
            end
            OP_BLANK: begin
               if (j == 4'h0) s = mk(K_WRS, A_555, 8'h33);
            end
            OP_CFI_ENTER: begin
               if (j == 4'h0) s = mk(K_WRS, A_055, 8'h98);
            end
            OP_CFI_EXIT: begin
               if (j == 4'h0) s = mk(K_WR, A_ZERO, 8'hFF);
            end
            OP_ID_ENTER: begin
               if (j == 4'h0) s = mk(K_WR, A_555, 8'h90);
            end
            OP_CONTINUITY: begin
               case (j)
                  4'h0:    s = mk(K_WR, A_555, 8'h71);
                  4'h1:    s = mk(K_WR, A_555, 8'h70);
                  4'h2:    s = mk(K_RD, A_ZERO, 8'h00);
                  4'h3:    begin
                     s      = mk(K_WR, A_CC1, 8'h00);
                     s.data = D_CC1;
                  end
                  4'h4:    begin
                     s      = mk(K_WR, A_CC2, 8'h00);
                     s.data = D_CC2;
                  end
                  4'h5:    s = mk(K_WR, A_555, 8'h70);
                  4'h6:    s = mk(K_RD, A_ZERO, 8'h00);
                  default: s = mk(K_END, A_ZERO, 8'h00);
               endcase
            end
            default: begin
               s = mk(K_END, A_ZERO, 8'h00);
            end
         endcase
      end
      return s;
   endfunction

   // Puts a low offset inside the command's sector.
   function automatic logic [ADDR_W-1:0] sect(input logic [ADDR_W-1:0] a,
                                              input logic [ADDR_W-1:0] lo);
      return {a[ADDR_W-1:SECT_LO_W], lo[SECT_LO_W-1:0]};
   endfunction

   assign step = fn_step(s_reg.cmd.op, s_reg.idx, s_reg.byp);

   // Accepts commands, walks their steps and issues bus cycles.
   always_comb begin
      s_next        = s_reg;
      s_next.done   = 1'b0;
      s_next.err    = 1'b0;
      s_next.rvalid = 1'b0;
      s_next.start  = 1'b0;
      case (s_reg.st)
         S_IDLE: begin
            if (cmd_valid_i && s_reg.ready) begin
               s_next.ready = 1'b0;
               s_next.cmd   = cmd_i;
               s_next.idx   = 4'h0;
               s_next.rem   = cmd_i.count;
               s_next.st    = S_STEP;
               // A full buffer is the most a load may carry.
               if (cmd_i.op == OP_BUF_PROG &&
                   (cmd_i.count == '0 || cmd_i.count > MAXW)) begin
                  s_next.ready = 1'b1;
                  s_next.err   = 1'b1;
                  s_next.st    = S_IDLE;
               end
            end
         end
         S_STEP: begin
            s_next.req.we   = 1'b1;
            s_next.req.addr = step.addr;
            s_next.req.data = step.data;
            s_next.start    = 1'b1;
            s_next.st       = S_WAIT;
            case (step.kind)
               K_END: begin
                  s_next.start = 1'b0;
                  s_next.done  = 1'b1;
                  s_next.ready = 1'b1;
                  s_next.st    = S_IDLE;
                  if (s_reg.cmd.op == OP_BYP_ENTER) s_next.byp = 1'b1;
                  if (s_reg.cmd.op == OP_BYP_EXIT) s_next.byp = 1'b0;
                  if (s_reg.cmd.op == OP_ID_ENTER ||
                      s_reg.cmd.op == OP_CFI_ENTER) s_next.ovl = 1'b1;
                  if (s_reg.cmd.op == OP_RESET ||
                      s_reg.cmd.op == OP_CFI_EXIT) s_next.ovl = 1'b0;
               end
               K_WRS: begin
                  s_next.req.addr = sect(s_reg.cmd.addr, step.addr);
               end
               K_WRU: begin
                  s_next.req.addr = s_reg.cmd.addr;
                  s_next.req.data = s_reg.cmd.data;
               end
               K_CNT: begin
                  s_next.req.addr = sect(s_reg.cmd.addr, A_ZERO);
                  s_next.req.data = DATA_W'(s_reg.cmd.count - 9'h001);
               end
               K_LOAD: begin
                  s_next.start = 1'b0;
                  if (s_reg.rem == '0) begin
                     s_next.idx = 4'(s_reg.idx + 4'h1);
                     s_next.st  = S_STEP;
                  end else begin
                     s_next.wready = 1'b1;
                     s_next.st     = S_LOAD;
                  end
               end
               K_RD: begin
                  s_next.req.we   = 1'b0;
                  s_next.req.addr = s_reg.cmd.addr;
               end
               default: begin
               end
            endcase
         end
         S_LOAD: begin
            // One buffered word per handshake, written at its own address.
            if (word_valid_i) begin
               s_next.wready   = 1'b0;
               s_next.req.we   = 1'b1;
               s_next.req.addr = word_i.addr;
               s_next.req.data = word_i.data;
               s_next.start    = 1'b1;
               s_next.st       = S_WAIT;
            end
         end
         S_WAIT: begin
            if (cyc_done) begin
               s_next.st = S_STEP;
               if (step.kind == K_LOAD) begin
                  s_next.rem = CNT_W'(s_reg.rem - 9'h001);
               end else begin
                  s_next.idx = 4'(s_reg.idx + 4'h1);
               end
               if (step.kind == K_RD) begin
                  s_next.rvalid = 1'b1;
                  s_next.rdata  = cyc_rdata;
               end
            end
         end
         default: begin
            s_next.st = S_IDLE;
         end
      endcase
   end

   // Registers the sequencer; the flash starts in normal array read.
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         s_reg       <= '0;
         s_reg.st    <= S_IDLE;
         s_reg.ready <= 1'b1;
      end else begin
         s_reg <= s_next;
      end
   end

   nfcd_bus_cycle u_cycle (
      .clk_i   (clk_i),
      .reset_i (reset_i),
      .start_i (s_reg.start),
      .req_i   (s_reg.req),
      .dq_i    (dq_i),
      .pins_o  (pins_o),
      .done_o  (cyc_done),
      .rdata_o (cyc_rdata)
   );

   assign cmd_ready_o     = s_reg.ready;
   assign word_ready_o    = s_reg.wready;
   assign done_o          = s_reg.done;
   assign err_o           = s_reg.err;
   assign rvalid_o        = s_reg.rvalid;
   assign rdata_o         = s_reg.rdata;
   assign bypass_o        = s_reg.byp;
   assign overlay_space_o = s_reg.ovl;

endmodule

// ==== nfcd_pkg.sv ====
// Shared types and constants of the NOR flash command sequencer.
// Assumes a 25 MHz host clock and an x16 flash behind plain async pins.
package nfcd_pkg;

   localparam int ADDR_W     = 26;
   localparam int DATA_W     = 16;
   localparam int CNT_W      = 9;
   localparam int SECT_LO_W  = 16;
   localparam int CLK_NS     = 40;

   // Bus timing in ns, turned into whole cycles below.
   localparam int T_SETUP_NS = 10;
   localparam int T_WE_NS    = 35;
   localparam int T_ACC_NS   = 100;
   localparam int T_HOLD_NS  = 20;
   localparam int SYNC_CYC   = 2;

   // Least times round up to whole cycles, never below one.
   function automatic logic [3:0] nfcd_cyc_up(input int ns);
      int c;
      c = (ns + CLK_NS - 1) / CLK_NS;
      if (c < 1) begin
         c = 1;
      end
      return 4'(c);
   endfunction

   localparam logic [3:0] SETUP_CYC = nfcd_cyc_up(T_SETUP_NS);
   localparam logic [3:0] WE_CYC    = nfcd_cyc_up(T_WE_NS);
   localparam logic [3:0] RD_CYC    = 4'(nfcd_cyc_up(T_ACC_NS) + SYNC_CYC);
   localparam logic [3:0] HOLD_CYC  = nfcd_cyc_up(T_HOLD_NS);

   // Word addresses and codes written on the bus.
   localparam logic [ADDR_W-1:0] A_555  = 26'h0000555;
   localparam logic [ADDR_W-1:0] A_2AA  = 26'h00002AA;
   localparam logic [ADDR_W-1:0] A_055  = 26'h0000055;
   localparam logic [ADDR_W-1:0] A_CC1  = 26'h2AAAA55;
   localparam logic [ADDR_W-1:0] A_CC2  = 26'h15555AA;
   localparam logic [ADDR_W-1:0] A_ZERO = 26'h0000000;
   localparam logic [DATA_W-1:0] D_CC1  = 16'hFF00;
   localparam logic [DATA_W-1:0] D_CC2  = 16'h00FF;

   typedef enum logic [4:0] {
      OP_READ       = 5'h00, OP_RESET      = 5'h01, OP_SR_READ    = 5'h02,
      OP_SR_CLEAR   = 5'h03, OP_WORD_PROG  = 5'h04, OP_BUF_PROG   = 5'h05,
      OP_BYP_ENTER  = 5'h06, OP_BYP_EXIT   = 5'h07, OP_CHIP_ERASE = 5'h08,
      OP_SECT_ERASE = 5'h09, OP_SUSP_LEG   = 5'h0A, OP_RES_LEG    = 5'h0B,
      OP_SUSP_ENH   = 5'h0C, OP_RES_ENH    = 5'h0D, OP_EVAL_ERASE = 5'h0E,
      OP_BLANK      = 5'h0F, OP_CFI_ENTER  = 5'h10, OP_CFI_EXIT   = 5'h11,
      OP_ID_ENTER   = 5'h12, OP_CONTINUITY = 5'h13
   } nfcd_op_t;

   typedef enum logic [2:0] {
      K_END = 3'h0, K_WR = 3'h1, K_WRS = 3'h2, K_WRU = 3'h3,
      K_CNT = 3'h4, K_LOAD = 3'h5, K_RD = 3'h6
   } nfcd_kind_t;

   typedef struct packed {
      nfcd_op_t          op;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
      logic [CNT_W-1:0]  count;
   } nfcd_cmd_t;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } nfcd_word_t;

   typedef struct packed {
      nfcd_kind_t        kind;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } nfcd_step_t;

   typedef struct packed {
      logic              we;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } nfcd_req_t;

   typedef struct packed {
      logic              ce_n;
      logic              oe_n;
      logic              we_n;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] dq_o;
      logic              dq_oe;
   } nfcd_pins_t;

endpackage

// ==== nfcd_bus_cycle.sv ====
// One asynchronous flash bus cycle, write or read, on registered pins.
// Assumes async flash data pins and synchronises them.
`timescale 1ns/1ns
module nfcd_bus_cycle
   import nfcd_pkg::*;
(
   input  wire logic              clk_i,
   input  wire logic              reset_i,
   input  wire logic              start_i,
   input  wire nfcd_req_t         req_i,
   input  wire logic [DATA_W-1:0] dq_i,
   output nfcd_pins_t             pins_o,
   output logic                   done_o,
   output logic [DATA_W-1:0]      rdata_o
);

   typedef enum logic [3:0] {
      C_IDLE = 4'h1, C_SETUP = 4'h2, C_PULSE = 4'h4, C_HOLD = 4'h8
   } nfcd_cst_t;

   typedef struct packed {
      nfcd_cst_t         st;
      logic [3:0]        cnt;
      logic              we;
      nfcd_pins_t        pins;
      logic              done;
      logic [DATA_W-1:0] rdata;
      logic [DATA_W-1:0] sync1;
      logic [DATA_W-1:0] sync2;
   } nfcd_cyc_state_t;

   nfcd_cyc_state_t s_reg;
   nfcd_cyc_state_t s_next;

   // Steps the strobes through setup, pulse and hold.
   always_comb begin
      s_next       = s_reg;
      s_next.done  = 1'b0;
      s_next.sync1 = dq_i;
      s_next.sync2 = s_reg.sync1;
      case (s_reg.st)
         C_IDLE: begin
            if (start_i) begin
               s_next.we         = req_i.we;
               s_next.pins.ce_n  = 1'b0;
               s_next.pins.addr  = req_i.addr;
               s_next.pins.dq_o  = req_i.data;
               s_next.pins.dq_oe = req_i.we;
               s_next.cnt        = SETUP_CYC;
               s_next.st         = C_SETUP;
            end
         end
         C_SETUP: begin
            s_next.cnt = 4'(s_reg.cnt - 4'h1);
            if (s_reg.cnt == 4'h1) begin
               s_next.pins.we_n = !s_reg.we;
               s_next.pins.oe_n = s_reg.we;
               s_next.cnt       = s_reg.we ? WE_CYC : RD_CYC;
               s_next.st        = C_PULSE;
            end
         end
         C_PULSE: begin
            s_next.cnt = 4'(s_reg.cnt - 4'h1);
            if (s_reg.cnt == 4'h1) begin
               // Data has settled and crossed both sync stages by now.
               if (!s_reg.we) begin
                  s_next.rdata = s_reg.sync2;
               end
               s_next.pins.we_n = 1'b1;
               s_next.pins.oe_n = 1'b1;
               s_next.cnt       = HOLD_CYC;
               s_next.st        = C_HOLD;
            end
         end
         C_HOLD: begin
            s_next.cnt = 4'(s_reg.cnt - 4'h1);
            if (s_reg.cnt == 4'h1) begin
               s_next.pins.ce_n  = 1'b1;
               s_next.pins.dq_oe = 1'b0;
               s_next.done       = 1'b1;
               s_next.st         = C_IDLE;
            end
         end
         default: begin
            s_next.st = C_IDLE;
         end
      endcase
   end

   // Registers the cycle state; strobes idle high after reset.
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         s_reg           <= '0;
         s_reg.st        <= C_IDLE;
         s_reg.pins.ce_n <= 1'b1;
         s_reg.pins.oe_n <= 1'b1;
         s_reg.pins.we_n <= 1'b1;
      end else begin
         s_reg <= s_next;
      end
   end

   assign pins_o  = s_reg.pins;
   assign done_o  = s_reg.done;
   assign rdata_o = s_reg.rdata;

endmodule

// ==== nfcd_flash_model.sv ====
// Behavioural x16 NOR flash on the host sequencer's pins.
// Assumes pins come straight from nfcd_host; the bench reads wlog by name.
`timescale 1ns/1ns
module nfcd_flash_model
   import nfcd_pkg::*;
#(
   parameter logic [DATA_W-1:0] STAT_VAL = 16'h0080
)(
   input  wire nfcd_pins_t   pins_i,
   output logic [DATA_W-1:0] dq_o
);
   logic [ADDR_W+DATA_W-1:0] wlog[$];
   logic [1:0]               unl_reg = 2'h0;
   logic                     sr_reg  = 1'b0;
   logic                     ov_reg  = 1'b0;
   logic [DATA_W-1:0]        rd_val;

   // Logs each finished write and tracks status, overlay and unlock state.
   always @(posedge pins_i.we_n) begin
      if (pins_i.ce_n == 1'b0) begin
         wlog.push_back({pins_i.addr, pins_i.dq_o});
         sr_reg  <= pins_i.addr == A_555 && pins_i.dq_o == 16'h0070;
         ov_reg  <= (ov_reg || (unl_reg == 2'h2 && pins_i.dq_o == 16'h0090)
                    || (pins_i.addr[15:0] == 16'h0055 && pins_i.dq_o == 16'h0098))
                    && pins_i.dq_o != 16'h00F0 && pins_i.dq_o != 16'h00FF;
         unl_reg <= (pins_i.addr == A_555 && pins_i.dq_o == 16'h00AA) ? 2'h1 :
                    (unl_reg == 2'h1 && pins_i.addr == A_2AA && pins_i.dq_o == 16'h0055)
                    ? 2'h2 : 2'h0;
      end
   end

   // Status answers one read cycle only.
   always @(posedge pins_i.oe_n) begin
      if (pins_i.ce_n == 1'b0) begin
         sr_reg <= 1'b0;
      end
   end

   // Reads give status, overlay or array data; a released bus shows the inverse.
   assign rd_val = sr_reg ? STAT_VAL :
                   ov_reg ? {8'h5A, pins_i.addr[7:0]} : pins_i.addr[15:0];
   assign dq_o   = (!pins_i.ce_n && !pins_i.oe_n) ? rd_val : ~rd_val;
endmodule

// ==== nfcd_host_chk.sv ====
// Concurrent checks on the host sequencer's command port and flash pins.
// Assumes binding into nfcd_host; sees only its ports.
`timescale 1ns/1ns
module nfcd_host_chk
   import nfcd_pkg::*;
#(
   parameter int MAX_WORDS = 256
)(
   input wire logic       clk_i,
   input wire logic       reset_i,
   input wire logic       cmd_valid_i,
   input wire nfcd_cmd_t  cmd_i,
   input wire logic       cmd_ready_o,
   input wire logic       err_o,
   input wire logic       rvalid_o,
   input wire nfcd_pins_t pins_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (reset_i);

   // A taken command, and a write strobe with address and code.
   sequence take_s(nfcd_op_t o);
      cmd_valid_i && cmd_ready_o && cmd_i.op == o;
   endsequence
   sequence write_s(logic [ADDR_W-1:0] a, logic [DATA_W-1:0] d);
      !pins_o.we_n && pins_o.addr == a && pins_o.dq_o == d;
   endsequence

   reset_idle_a: assert property (
      $fell(reset_i) |-> pins_o.ce_n && pins_o.oe_n && pins_o.we_n && cmd_ready_o)
      else $error("pins not idle after reset");
   write_qual_a: assert property (
      !pins_o.we_n |-> !pins_o.ce_n && pins_o.oe_n && pins_o.dq_oe)
      else $error("write without select or drive");
   write_pulse_a: assert property (
      $fell(pins_o.we_n) |=> pins_o.we_n ##1 !pins_o.dq_oe)
      else $error("write pulse too long");
   read_pulse_a: assert property (
      $fell(pins_o.oe_n) |-> !pins_o.oe_n [*5] ##1 pins_o.oe_n)
      else $error("read strobe not five cycles");
   read_quiet_a: assert property (
      !pins_o.oe_n |-> !pins_o.dq_oe && pins_o.we_n && !pins_o.ce_n)
      else $error("bus driven during read");
   read_answer_a: assert property (
      $rose(pins_o.oe_n) |-> ##[1:4] rvalid_o)
      else $error("read data not returned");
   buf_refuse_a: assert property (
      take_s(OP_BUF_PROG) ##0 (cmd_i.count == 0 || cmd_i.count > MAX_WORDS)
      |=> err_o && cmd_ready_o && pins_o.ce_n)
      else $error("bad buffer count not refused");
   clear_write_a: assert property (
      take_s(OP_SR_CLEAR) |-> ##[1:6] write_s(A_555, 16'h0071))
      else $error("no status clear write");
   reset_write_a: assert property (
      take_s(OP_RESET) |-> ##[1:6] write_s(A_ZERO, 16'h00F0))
      else $error("no return-to-read write");
   id_unlock_a: assert property (
      take_s(OP_ID_ENTER) |-> ##[1:6] write_s(A_555, 16'h00AA))
      else $error("no first unlock write");
endmodule

bind nfcd_host nfcd_host_chk #(.MAX_WORDS(MAX_WORDS)) u_chk (
   .clk_i(clk_i), .reset_i(reset_i), .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i),
   .cmd_ready_o(cmd_ready_o), .err_o(err_o), .rvalid_o(rvalid_o), .pins_o(pins_o));

// ==== tb_nfcd_host.sv ====
// Bench: runs every command and compares the flash write log.
// Assumes nfcd_flash_model and a 25 MHz clock.
`timescale 1ns/1ns
module tb_nfcd_host;
   import nfcd_pkg::*;
   localparam logic [ADDR_W-1:0] SEC = 26'h0130000;
   logic clk_i = 1'b0, reset_i = 1'b1, cmd_valid_i = 1'b0, word_valid_i = 1'b0;
   nfcd_cmd_t cmd_i = '0;
   nfcd_word_t word_i = '0;
   logic cmd_ready_o, word_ready_o, done_o, err_o, rvalid_o, bypass_o, overlay_space_o, err_seen;
   logic [DATA_W-1:0] rdata_o, dq_i, rq[$];
   nfcd_pins_t pins_o;
   logic [ADDR_W+DATA_W-1:0] ex[$];
   nfcd_word_t wq[$];
   int num_errors, tests_run, cycles;

   nfcd_host #(.MAX_WORDS(256)) dut (.clk_i(clk_i), .reset_i(reset_i),
      .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i), .cmd_ready_o(cmd_ready_o),
      .word_valid_i(word_valid_i), .word_i(word_i), .word_ready_o(word_ready_o),
      .done_o(done_o), .err_o(err_o), .rvalid_o(rvalid_o), .rdata_o(rdata_o),
      .bypass_o(bypass_o), .overlay_space_o(overlay_space_o), .pins_o(pins_o), .dq_i(dq_i));
   nfcd_flash_model flash (.pins_i(pins_o), .dq_o(dq_i));

   // Clock, and a cycle ceiling against hangs.
   initial begin
      forever #20 clk_i = ~clk_i;
   end
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         num_errors++;
         end_sim();
      end
   end

   // Compares and counts one value.
   task automatic chk(input logic [41:0] seen, exp);
      tests_run++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   function automatic void e(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      ex.push_back({a, d});
   endfunction
   function automatic void ul();
      e(A_555, 16'h00AA);
      e(A_2AA, 16'h0055);
   endfunction
   function automatic logic [DATA_W-1:0] rd();
      return rq.size() ? rq.pop_front() : 16'hXXXX;
   endfunction

   // Issues a command, feeds queued words, matches the write log.
   task automatic run(input nfcd_op_t op, input logic [ADDR_W-1:0] a = A_ZERO,
                      input logic [DATA_W-1:0] d = '0, input logic [CNT_W-1:0] n = '0);
      bit acc;
      cmd_i = '{op, a, d, n};
      cmd_valid_i = 1'b1;
      repeat (4000) begin
         @(negedge clk_i);
         cmd_valid_i = 1'b0;
         if (rvalid_o === 1'b1) rq.push_back(rdata_o);
         if (done_o === 1'b1 || err_o === 1'b1) break;
         if (acc) void'(wq.pop_front());
         word_valid_i = wq.size() > 0;
         if (word_valid_i) word_i = wq[0];
         acc = word_valid_i && word_ready_o;
      end
      err_seen = err_o;
      chk(42'(flash.wlog.size()), 42'(ex.size()));
      foreach (ex[i]) if (i < flash.wlog.size()) chk(flash.wlog[i], ex[i]);
      ex.delete();
      flash.wlog.delete();
   endtask

   task automatic t_single;
      nfcd_op_t ops[9] = '{OP_SR_CLEAR, OP_RESET, OP_SUSP_LEG, OP_RES_LEG, OP_SUSP_ENH,
                           OP_RES_ENH, OP_EVAL_ERASE, OP_BLANK, OP_CFI_EXIT};
      logic [DATA_W-1:0] cd[9] = '{16'h0071, 16'h00F0, 16'h00B0, 16'h0030, 16'h0051,
                                   16'h0050, 16'h0035, 16'h0033, 16'h00FF};
      for (int i = 0; i < 9; i++) begin
         e(i == 0 ? A_555 : i inside {6, 7} ? SEC | A_555 : A_ZERO, cd[i]);
         run(ops[i], SEC);
      end
   endtask
   task automatic t_status;
      e(A_555, 16'h0070);
      run(OP_SR_READ, 26'h0000123);
      chk(rd(), 16'h0080);
      run(OP_READ, 26'h0001234);
      chk(rd(), 16'h1234);
   endtask
   task automatic t_prog;
      ul();
      e(A_555, 16'h00A0);
      e(26'h0200040, 16'hBEEF);
      run(OP_WORD_PROG, 26'h0200040, 16'hBEEF);
      ul();
      e(A_555, 16'h0080);
      ul();
      e(A_555, 16'h0010);
      run(OP_CHIP_ERASE);
      ul();
      e(A_555, 16'h0080);
      ul();
      e(SEC, 16'h0030);
      run(OP_SECT_ERASE, SEC);
   endtask
   task automatic t_buf;
      run(OP_BUF_PROG, SEC);
      chk(err_seen, 1'b1);
      run(OP_BUF_PROG, SEC, '0, 9'h101);
      chk(err_seen, 1'b1);
      ul();
      e(SEC, 16'h0025);
      e(SEC, 16'h00FF);
      for (int i = 0; i < 256; i++) begin
         wq.push_back({SEC | 26'(i), 16'(i)});
         e(SEC | 26'(i), 16'(i));
      end
      e(SEC, 16'h0029);
      run(OP_BUF_PROG, SEC, '0, 9'h100);
   endtask
   task automatic t_bypass;
      ul();
      e(A_555, 16'h0020);
      run(OP_BYP_ENTER);
      chk(bypass_o, 1'b1);
      e(A_555, 16'h00A0);
      e(26'h0000100, 16'h1357);
      run(OP_WORD_PROG, 26'h0000100, 16'h1357);
      e(SEC, 16'h0025);
      e(SEC, 16'h0000);
      e(SEC | 26'h0000009, 16'h2468);
      e(SEC, 16'h0029);
      wq.push_back({SEC | 26'h0000009, 16'h2468});
      run(OP_BUF_PROG, SEC, '0, 9'h001);
      e(A_555, 16'h0080);
      e(A_555, 16'h0010);
      run(OP_CHIP_ERASE);
      e(A_555, 16'h0080);
      e(SEC, 16'h0030);
      run(OP_SECT_ERASE, SEC);
      e(A_ZERO, 16'h0090);
      e(A_ZERO, 16'h0000);
      run(OP_BYP_EXIT);
      chk(bypass_o, 1'b0);
   endtask
   task automatic t_overlay;
      ul();
      e(A_555, 16'h0090);
      run(OP_ID_ENTER);
      chk(overlay_space_o, 1'b1);
      run(OP_READ, 26'h0000012);
      chk(rd(), 16'h5A12);
      e(A_ZERO, 16'h00F0);
      run(OP_RESET);
      chk(overlay_space_o, 1'b0);
      e(SEC | A_055, 16'h0098);
      run(OP_CFI_ENTER, SEC);
      run(OP_READ, 26'h0000034);
      chk(rd(), 16'h5A34);
      e(A_ZERO, 16'h00FF);
      run(OP_CFI_EXIT);
      run(OP_READ, 26'h0000034);
      chk(rd(), 16'h0034);
   endtask
   task automatic t_cont;
      e(A_555, 16'h0071);
      e(A_555, 16'h0070);
      e(A_CC1, D_CC1);
      e(A_CC2, D_CC2);
      e(A_555, 16'h0070);
      run(OP_CONTINUITY);
      chk(rd(), 16'h0080);
      chk(rd(), 16'h0080);
   endtask

   // Prints counts and verdict, then stops.
   task automatic end_sim;
      $display("checks=%0d errors=%0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // Six reset cycles, then each scenario.
   initial begin
      repeat (6) @(negedge clk_i);
      reset_i = 1'b0;
      t_single();
      t_status();
      t_prog();
      t_buf();
      t_bypass();
      t_overlay();
      t_cont();
      end_sim();
   end
endmodule
